// ---- uab_consts.vh ----
// register offsets, field positions, reset values and encodings of the transfer control block
`ifndef UAB_CONSTS_VH
`define UAB_CONSTS_VH

`define UAB_ADDR_W 12
`define UAB_OFF_EP_SET 12'h000
`define UAB_OFF_MST_SET 12'h004
`define UAB_OFF_MST_STS 12'h008

`define UAB_EP_NULL_BIT 0
`define UAB_EP_EOP_EN_BIT 4
`define UAB_EOP_EN_RESET 1'b1

`define UAB_MST_WR_EN_BIT 0
`define UAB_MST_WR_ABORT_BIT 1
`define UAB_MST_WR_RESET_BIT 2
`define UAB_MST_RD_EN_BIT 4
`define UAB_MST_RD_ABORT_BIT 5
`define UAB_MST_RD_RESET_BIT 6
`define UAB_MST_BURST_BIT 8
`define UAB_MST_RESET 32'h00000000

`define UAB_STS_EP_EMPTY_BIT 0
`define UAB_STS_RD_BUSY_BIT 1
`define UAB_STS_WR_BUSY_BIT 2
`define UAB_STS_NULL_BUSY_BIT 3

`define UAB_HBURST_SINGLE 3'h0
`define UAB_HBURST_INCR 3'h1
`define UAB_HBURST_INCR8 3'h5

`endif

// ---- uab_ep_model.sv ----
// endpoint stand-in: slow word acceptance, delayed null packet end
`timescale 1ns/1ps
`default_nettype none
module uab_ep_model (
  // clock, reset, endpoint handshake
  input wire logic pclk, presetn, ep_w_valid, zl,
  output logic ep_w_ready, ep_null_done
);
  logic [1:0] cnt_reg;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) {cnt_reg, ep_w_ready, ep_null_done} <= 4'h0;
    else begin
      // one stall per word so held data gets checked
      ep_w_ready <= ep_w_valid && !ep_w_ready;
      cnt_reg <= (zl && !ep_null_done) ? cnt_reg + 2'h1 : 2'h0;
      ep_null_done <= cnt_reg == 2'h3;
    end
endmodule // uab_ep_model
`default_nettype wire

// ---- uab_xfer_ctrl.v ----
// transfer control of the endpoint to system bus bridge: registers, read path, burst select
//
// Decided for this implementation: the APB register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "uab_consts.vh"

module uab_xfer_ctrl (
  // apb slave
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`UAB_ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // read path data from system memory, 16-bit half words
  input wire rd_src_valid,
  input wire [15:0] rd_src_data,
  input wire rd_src_last,
  input wire rd_src_two_bytes,
  output reg rd_src_ready,
  // endpoint write side
  output reg ep_w_valid,
  output reg [15:0] ep_w_data,
  output reg ep_w_two_bytes,
  output reg ep_w_eop,
  input wire ep_w_ready,
  input wire ep_empty,
  input wire ep_null_done,
  output reg endpoint_zero_length_transmit,
  // write path engine and read path control
  input wire wr_path_done,
  output reg write_path_enable,
  output reg write_path_reset,
  output reg read_path_enable,
  output reg read_path_reset,
  // bus master burst request
  input wire beat_is_burst,
  output reg [2:0] hburst
);

  reg eop_en_reg;
  reg burst_type_reg;
  reg hold_reg;
  reg hold_last_reg;
  reg hold_next;
  reg rd_en_next;
  reg null_next;
  wire wr_acc;
  wire rd_acc;
  wire ep_sel;
  wire mst_sel;
  wire sts_sel;
  wire rd_take;
  wire rd_skip;
  wire rd_done;
  wire rd_kill;
  wire wr_kill;

  function is_reg;
    input [`UAB_ADDR_W-1:0] addr;
    input [`UAB_ADDR_W-1:0] off;
    begin
      is_reg = (addr == off);
    end
  endfunction

  // access completes in the first access cycle, no wait states
  assign wr_acc = psel & penable & pready & pwrite;
  assign rd_acc = psel & penable & pready & ~pwrite;
  assign ep_sel = is_reg(paddr, `UAB_OFF_EP_SET);
  assign mst_sel = is_reg(paddr, `UAB_OFF_MST_SET);
  assign sts_sel = is_reg(paddr, `UAB_OFF_MST_STS);

  // abort and reset act only on a written 1
  assign rd_kill = wr_acc & mst_sel &
    (pwdata[`UAB_MST_RD_ABORT_BIT] | pwdata[`UAB_MST_RD_RESET_BIT]);
  assign wr_kill = wr_acc & mst_sel &
    (pwdata[`UAB_MST_WR_ABORT_BIT] | pwdata[`UAB_MST_WR_RESET_BIT]);

  assign rd_take = rd_src_valid & rd_src_ready;
  // one-byte tail dropped when eop is off
  assign rd_skip = rd_take & rd_src_last & ~rd_src_two_bytes & ~eop_en_reg;
  assign rd_done = rd_skip | (ep_w_valid & ep_w_ready & hold_last_reg);

  always @* begin
    hold_next = hold_reg;
    if (ep_w_valid & ep_w_ready) begin
      hold_next = 1'b0;
    end
    if (rd_take & ~rd_skip) begin
      hold_next = 1'b1;
    end
    if (rd_kill) begin
      hold_next = 1'b0;
    end
  end

  always @* begin
    rd_en_next = read_path_enable;
    if (wr_acc & mst_sel & pwdata[`UAB_MST_RD_EN_BIT]) begin
      rd_en_next = 1'b1;
    end
    if (rd_done) begin
      rd_en_next = 1'b0;
    end
    if (rd_kill) begin
      rd_en_next = 1'b0;
    end
  end

  // request set beats the done clear in the same cycle
  always @* begin
    null_next = endpoint_zero_length_transmit;
    if (ep_null_done) begin
      null_next = 1'b0;
    end
    if (wr_acc & ep_sel & pwdata[`UAB_EP_NULL_BIT] & ep_empty) begin
      null_next = 1'b1;
    end
  end

  // apb answer and read data
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~(ep_sel | mst_sel | sts_sel);
      if (psel & ~penable & ~pwrite) begin
        prdata <= 32'h00000000;
        if (ep_sel) begin
          prdata[`UAB_EP_EOP_EN_BIT] <= eop_en_reg;
          prdata[`UAB_EP_NULL_BIT] <= endpoint_zero_length_transmit;
        end else if (mst_sel) begin
          // abort bits are write-only and read as 0
          prdata[`UAB_MST_BURST_BIT] <= burst_type_reg;
          prdata[`UAB_MST_RD_RESET_BIT] <= read_path_reset;
          prdata[`UAB_MST_RD_EN_BIT] <= read_path_enable;
          prdata[`UAB_MST_WR_RESET_BIT] <= write_path_reset;
          prdata[`UAB_MST_WR_EN_BIT] <= write_path_enable;
        end else if (sts_sel) begin
          prdata[`UAB_STS_EP_EMPTY_BIT] <= ep_empty;
          prdata[`UAB_STS_RD_BUSY_BIT] <= read_path_enable;
          prdata[`UAB_STS_WR_BUSY_BIT] <= write_path_enable;
          prdata[`UAB_STS_NULL_BUSY_BIT] <= endpoint_zero_length_transmit;
        end
      end
    end
  end

  // configuration and control
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eop_en_reg <= `UAB_EOP_EN_RESET;
      burst_type_reg <= 1'b0;
      read_path_enable <= 1'b0;
      read_path_reset <= 1'b0;
      write_path_enable <= 1'b0;
      write_path_reset <= 1'b0;
      endpoint_zero_length_transmit <= 1'b0;
    end else begin
      if (wr_acc & ep_sel) begin
        eop_en_reg <= pwdata[`UAB_EP_EOP_EN_BIT];
      end
      if (wr_acc & mst_sel) begin
        burst_type_reg <= pwdata[`UAB_MST_BURST_BIT];
      end
      endpoint_zero_length_transmit <= null_next;
      read_path_enable <= rd_en_next;
      // reset pulses one cycle, then reads back 0
      read_path_reset <= wr_acc & mst_sel & pwdata[`UAB_MST_RD_RESET_BIT];
      write_path_reset <= wr_acc & mst_sel & pwdata[`UAB_MST_WR_RESET_BIT];
      if (wr_kill) begin
        write_path_enable <= 1'b0;
      end else if (wr_path_done) begin
        write_path_enable <= 1'b0;
      end else if (wr_acc & mst_sel & pwdata[`UAB_MST_WR_EN_BIT]) begin
        write_path_enable <= 1'b1;
      end
    end
  end

  // read path: one half word staged toward the endpoint
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_reg <= 1'b0;
      hold_last_reg <= 1'b0;
      rd_src_ready <= 1'b0;
      ep_w_valid <= 1'b0;
      ep_w_data <= 16'h0000;
      ep_w_two_bytes <= 1'b0;
      ep_w_eop <= 1'b0;
    end else begin
      hold_reg <= hold_next;
      ep_w_valid <= hold_next;
      // ready registered from next state, so no take while a word is staged
      rd_src_ready <= rd_en_next & ~hold_next & ~rd_done;
      if (rd_take & ~rd_skip) begin
        ep_w_data <= rd_src_data;
        ep_w_two_bytes <= rd_src_two_bytes;
        hold_last_reg <= rd_src_last;
        ep_w_eop <= rd_src_last & eop_en_reg;
      end
      if (rd_kill) begin
        hold_last_reg <= 1'b0;
        ep_w_eop <= 1'b0;
      end
    end
  end

  // burst encoding; single beats ignore the burst type
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hburst <= `UAB_HBURST_SINGLE;
    end else if (!beat_is_burst) begin
      hburst <= `UAB_HBURST_SINGLE;
    end else if (burst_type_reg) begin
      hburst <= `UAB_HBURST_INCR;
    end else begin
      hburst <= `UAB_HBURST_INCR8;
    end
  end

endmodule // uab_xfer_ctrl
`default_nettype wire

// ---- uab_xfer_ctrl_bench.sv ----
// self-checking bench of the transfer control block
`timescale 1ns/1ps
`default_nettype none
module uab_xfer_ctrl_bench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rd_src_valid, rd_src_last;
  logic rd_src_two_bytes, rd_src_ready, ep_w_valid, ep_w_two_bytes, ep_w_eop, ep_w_ready;
  logic ep_empty, ep_null_done, endpoint_zero_length_transmit, wr_path_done, beat_is_burst;
  logic write_path_enable, write_path_reset, read_path_enable, read_path_reset, se, eo;
  logic [11:0] paddr;
  logic [15:0] rd_src_data, ep_w_data;
  logic [31:0] pwdata, prdata, rdv;
  logic [2:0] hburst;
  int fail_count, n_compared, nw, n;
  uab_xfer_ctrl u_dut (.*);
  uab_ep_model u_ep (.pclk, .presetn, .ep_w_valid, .ep_w_ready, .ep_null_done,
    .zl(endpoint_zero_length_transmit));
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  always @(posedge pclk) if (ep_w_valid && ep_w_ready) begin
    nw++;
    eo = ep_w_eop;
  end
  task automatic report_and_stop;
    $display("compared %0d failed %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, e);
    n_compared++;
    if (s !== e) begin
      fail_count++;
      $display("[ERR] %s exp %h seen %h", nm, e, s);
    end
  endtask
  // a stuck handshake ends the run
  task automatic lim;
    n++;
    if (n > 40) begin
      fail_count++;
      report_and_stop;
    end
  endtask
  task automatic ap(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk) {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge pclk) penable <= 1'b1;
    n = 0;
    // pready, read data and error are taken at the rising edge that completes the access
    do begin @(posedge pclk); lim; end while (pready !== 1'b1);
    rdv = prdata;
    se = pslverr;
    {psel, penable} <= 2'h0;
  endtask
  task automatic hw(input logic l, t);
    @(posedge pclk) {rd_src_valid, rd_src_data, rd_src_last, rd_src_two_bytes} <= {1'b1, 16'hA5C3, l, t};
    n = 0;
    do begin @(posedge pclk); lim; end while (rd_src_ready !== 1'b1);
    rd_src_valid <= 1'b0;
  endtask
  initial begin
    {psel, penable, pwrite, rd_src_valid, rd_src_last, rd_src_two_bytes} = 6'h0;
    {wr_path_done, beat_is_burst, ep_empty, presetn, paddr, pwdata, rd_src_data} = 64'h0;
    {fail_count, n_compared, nw} = 96'h0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    ap(0, 12'h000, 32'h0);
    chk("ep set", rdv & 32'h11, 32'h10);
    ap(0, 12'h004, 32'h0);
    chk("mst set", rdv & 32'h177, 32'h0);
    ap(0, 12'hFFC, 32'h0);
    chk("unmapped", se, 32'h1);
    ap(1, 12'h004, 32'h1);
    @(negedge pclk) chk("wr en", write_path_enable, 32'h1);
    @(posedge pclk) wr_path_done <= 1'b1;
    @(posedge pclk) wr_path_done <= 1'b0;
    @(negedge pclk) chk("wr done", write_path_enable, 32'h0);
    ap(1, 12'h000, 32'h11);
    ap(0, 12'h000, 32'h0);
    chk("null busy", rdv[0], 32'h0);
    ep_empty <= 1'b1;
    ap(1, 12'h000, 32'h11);
    @(negedge pclk) chk("zero len", endpoint_zero_length_transmit, 32'h1);
    n = 0;
    // no new endpoint data until the request drops
    do begin @(negedge pclk); lim; end while (endpoint_zero_length_transmit !== 1'b0);
    ap(0, 12'h000, 32'h0);
    chk("null clr", rdv[0], 32'h0);
    for (int i = 0; i < 3; i++) begin
      ap(1, 12'h000, (i == 0) ? 32'h10 : 32'h0);
      {nw, eo} = 33'h0;
      ap(1, 12'h004, 32'h10);
      hw(0, 1);
      if (i == 1) ap(1, 12'h004, 32'h0);
      hw(1, i == 1);
      n = 0;
      do begin @(negedge pclk); lim; end while (read_path_enable !== 1'b0);
      chk("words", nw, (i == 2) ? 32'h1 : 32'h2);
      chk("eop", eo, i == 0);
    end
    ap(1, 12'h004, 32'h10);
    hw(0, 1);
    ap(1, 12'h004, 32'h20);
    @(negedge pclk) chk("rd abort", read_path_enable, 32'h0);
    ap(1, 12'h004, 32'h44);
    // burst type set once here, back to 0 for normal use
    for (int k = 0; k < 3; k++) begin
      ap(1, 12'h004, (k == 0) ? 32'h100 : 32'h0);
      beat_is_burst <= (k < 2);
      repeat (2) @(negedge pclk);
      chk("hburst", hburst, (k == 0) ? 32'h1 : (k == 1) ? 32'h5 : 32'h0);
    end
    report_and_stop;
  end
endmodule // uab_xfer_ctrl_bench
`default_nettype wire

// ---- uab_xfer_ctrl_checker.sv ----
// port assertions of the transfer control block
`timescale 1ns/1ps
`default_nettype none
module uab_xfer_ctrl_checker (
  // apb
  input wire logic pclk, presetn, psel, penable, pwrite, pready,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  // endpoint, paths, burst
  input wire logic ep_empty, ep_null_done, endpoint_zero_length_transmit,
  input wire logic ep_w_valid, ep_w_ready, ep_w_eop, read_path_enable, read_path_reset,
  input wire logic write_path_reset, beat_is_burst,
  input wire logic [15:0] ep_w_data,
  input wire logic [2:0] hburst
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic wr = psel && penable && pready && pwrite;
  wire logic we = wr && paddr == 12'h000 && pwdata[0];
  wire logic wm = wr && paddr == 12'h004;
  wire logic zl = endpoint_zero_length_transmit;
  logic bq;
  logic [2:0] hx;
  // expected burst code, one cycle behind its request
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) {bq, hx} <= 4'h0;
    else begin
      bq <= wm ? pwdata[8] : bq;
      hx <= !beat_is_burst ? 3'h0 : bq ? 3'h1 : 3'h5;
    end
  AST_NULL_SET: assert property (we && ep_empty |=> zl)
    else $error("null not set");
  AST_NULL_IGN: assert property (we && !ep_empty && !zl |=> !zl)
    else $error("null not ignored");
  AST_NULL_CLR: assert property (zl && ep_null_done && !we |=> !zl)
    else $error("null not cleared");
  AST_NULL_HOLD: assert property (zl && !ep_null_done |=> zl)
    else $error("null dropped");
  AST_RD_ABORT: assert property (wm && pwdata[5] |=> !read_path_enable)
    else $error("abort ignored");
  AST_RD_RST: assert property (wm && pwdata[6] |=> read_path_reset ##1 !read_path_reset)
    else $error("read reset pulse");
  AST_WR_RST: assert property (wm && pwdata[2] |=> write_path_reset ##1 !write_path_reset)
    else $error("write reset pulse");
  AST_BURST: assert property (hburst == hx)
    else $error("burst code");
  AST_EP_HOLD: assert property (
    ep_w_valid && !ep_w_ready |=> $stable({ep_w_valid, ep_w_data, ep_w_eop}))
    else $error("word not held");
  cover property (zl ##1 !zl);
  cover property (ep_w_valid && ep_w_ready && ep_w_eop);
  cover property (wm && pwdata[5] && read_path_enable);
endmodule // uab_xfer_ctrl_checker
bind uab_xfer_ctrl uab_xfer_ctrl_checker u_chk (.*);
`default_nettype wire
